// ===== design/acc_map.svh
// acc_map.svh: field positions, select codes, reset values and timing counts of the
// converter control block; assumes a 50 MHz system clock.
// Operation
// - completion always sets done flag
// - irq only when enable and flag
// - converter irq wakes sleeping device
// - wake runs next instruction, isr if enabled
// - sleep conversion only with rc clock
// - format bit picks twos or sign-magnitude
// - sign-magnitude left-justified, sign in bit0
// - twos complement right-justified, sign-extended
// - start clears results and begins conversion
// - completion clears status, sets flag
// - clearing status aborts, result stays cleared
// - reset clears registers, stops conversion
// - rc clock delays start three cycles
// - rc sleep without irq powers down
// - non-rc clock sleep aborts, powers down
// - trigger edge sets status, resets timer
// - four-bit field selects trigger source
// - conversion takes fifteen bit periods
// - clock select maps divider codes
// - status bit1, enable bit0 of control 0
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
`define ACC_CTRL0_ENABLE_BIT  0
`define ACC_CTRL0_STATUS_BIT  1
`define ACC_CONV_PERIODS      4'd15
`define ACC_INSTR_CYCLES      2'd3
`define ACC_RC_DIV            7'd79
`define ACC_RESULT_RESET      16'h0000
`define ACC_CLK_DIV2          3'b000
`define ACC_CLK_DIV4          3'b100
`define ACC_CLK_DIV8          3'b001
`define ACC_CLK_DIV16         3'b101
`define ACC_CLK_DIV32         3'b010
`define ACC_CLK_DIV64         3'b110
`define ACC_TRIG_CAPCOMP1     4'h1
`define ACC_TRIG_CAPCOMP2     4'h2
`define ACC_TRIG_PWM_FIRST    4'h4
`define ACC_TRIG_PWM_LAST     4'h9
`endif

// ===== design/acc_pkg.sv
// acc_pkg.sv: types shared by the converter control block.
// assumes acc_map.svh supplies the numeric constants.
package acc_pkg;
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_DELAY,
        ACC_CONVERT
    } acc_state_t;
endpackage

// ===== design/acc_tick_gen.sv
// acc_tick_gen.sv: bit period tick generator for the conversion clock.
// assumes the rc oscillator is modelled by a fixed divider of the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.svh"
module acc_tick_gen (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // control
    input  wire logic       run,
    input  wire logic [2:0] conv_clock_select,
    // tick out
    output var  logic       tick
);
    logic [6:0] cnt_reg;   // cycles since last tick
    logic [6:0] limit;     // terminal count
    always_comb begin
        case (conv_clock_select)
            `ACC_CLK_DIV2:  limit = 7'd1;
            `ACC_CLK_DIV4:  limit = 7'd3;
            `ACC_CLK_DIV8:  limit = 7'd7;
            `ACC_CLK_DIV16: limit = 7'd15;
            `ACC_CLK_DIV32: limit = 7'd31;
            `ACC_CLK_DIV64: limit = 7'd63;
            default:        limit = `ACC_RC_DIV; // x11 selects rc clock
        endcase
    end
    assign tick = run && (cnt_reg == limit);
    // counter restarts whenever the converter is idle so periods align to start
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !run || tick) begin
            cnt_reg <= 7'd0;
        end else begin
            cnt_reg <= cnt_reg + 7'd1;
        end
    end
endmodule
`default_nettype wire

// ===== design/acc_conv_ctrl.sv
// acc_conv_ctrl.sv: converter control: start, abort, completion, flag,
// wake, auto trigger and result formatting.
// assumes the analog core hands a 13-bit sign-magnitude sample at completion.
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.svh"
module acc_conv_ctrl (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // control register write (one-cycle strobe) and held settings
    input  wire logic        ctrl0_wr,
    input  wire logic [7:0]  ctrl0_wdata,
    input  wire logic        result_format_sel,
    input  wire logic        result_width_mode,
    input  wire logic [2:0]  conv_clock_select,
    input  wire logic [3:0]  auto_trigger_select,
    // interrupt control
    input  wire logic        conv_irq_enable,
    input  wire logic        global_irq_enable,
    input  wire logic        periph_irq_enable,
    input  wire logic        done_flag_clear,
    // device state
    input  wire logic        cpu_sleep,
    // trigger sources
    input  wire logic        capcomp_unit_1,
    input  wire logic        capcomp_unit_2,
    input  wire logic [5:0]  pwm_ctrl_events,
    // analog core sample, sign bit 12 and magnitude 11:0
    input  wire logic [12:0] core_sample,
    // status and results
    output var  logic        converter_enable,
    output var  logic        conv_status,
    output var  logic        conv_done_flag,
    output var  logic        conv_irq,
    output var  logic        cpu_wake,
    output var  logic        cpu_vector_isr,
    output var  logic        core_powered,
    output var  logic        timer_reset,
    output var  logic [7:0]  result_high,
    output var  logic [7:0]  result_low
);
    import acc_pkg::*;

    acc_state_t  state_reg, state_next;   // conversion sequencer
    logic        enable_reg;              // converter enable
    logic        status_reg, status_next; // conversion status
    logic        flag_reg;                // completion flag
    logic        irq_reg;                 // interrupt request
    logic        wake_reg;                // wake request, held while asleep with the flag pending and irq enabled
    logic        isr_reg;                 // branch to service routine
    logic        power_reg;               // analog core powered
    logic        trst_reg;                // timer reset pulse
    logic        trig_prev_reg;           // trigger for edge detect
    logic [3:0]  period_reg;              // bit periods elapsed
    logic [1:0]  delay_reg;               // rc start delay counter
    logic [15:0] result_reg;              // result pair
    logic        tick;                    // one bit period
    logic        rc_clock;                // rc clock selected
    logic        sw_start;                // software start write
    logic        sw_clear;                // software abort write
    logic        trig_level;              // selected trigger level
    logic        trig_edge;               // rising trigger edge
    logic        start_req;               // any accepted start
    logic        complete;                // last bit period
    logic        sleep_abort;             // sleep kills non-rc conversion
    logic [15:0] fmt_sm;                  // sign-magnitude image
    logic [15:0] fmt_tc;                  // twos complement image
    logic [12:0] tc_val;                  // signed value
    logic [15:0] fmt_out;                 // chosen image

    assign rc_clock = conv_clock_select[1:0] == 2'b11;
    // status bit 1, enable bit 0
    assign sw_start = ctrl0_wr && ctrl0_wdata[`ACC_CTRL0_STATUS_BIT];
    assign sw_clear = ctrl0_wr && !ctrl0_wdata[`ACC_CTRL0_STATUS_BIT];

    assign trig_level =
        (auto_trigger_select == `ACC_TRIG_CAPCOMP1) ? capcomp_unit_1 :
        (auto_trigger_select == `ACC_TRIG_CAPCOMP2) ? capcomp_unit_2 :
        (auto_trigger_select >= `ACC_TRIG_PWM_FIRST &&
         auto_trigger_select <= `ACC_TRIG_PWM_LAST)
            ? pwm_ctrl_events[3'(auto_trigger_select - `ACC_TRIG_PWM_FIRST)] : 1'b0;
    assign trig_edge = trig_level && !trig_prev_reg;

    // disabled converter ignores starts; relied on
    assign start_req = enable_reg && state_reg == ACC_IDLE && (sw_start || trig_edge)
                       && !(ctrl0_wr && !ctrl0_wdata[`ACC_CTRL0_ENABLE_BIT]);
    assign complete = state_reg == ACC_CONVERT && tick &&
                      period_reg == `ACC_CONV_PERIODS - 4'd1;
    assign sleep_abort = cpu_sleep && !rc_clock && state_reg != ACC_IDLE;

    acc_tick_gen u_tick (
        .clk_sys           (clk_sys),
        .sys_rst           (sys_rst),
        .run               (state_reg == ACC_CONVERT),
        .conv_clock_select (conv_clock_select),
        .tick              (tick)
    );

    // sign-magnitude left-justified, sign in bit 0
    assign fmt_sm = {core_sample[11:0], 3'b000, core_sample[12]};
    // convert to signed and sign-extend right-justified
    // a negative zero magnitude stands for the full-scale negative value
    assign tc_val = core_sample[12]
                    ? (13'(~{1'b0, core_sample[11:0]} + 13'd1) | 13'h1000)
                    : {1'b0, core_sample[11:0]};
    assign fmt_tc = {{3{tc_val[12]}}, tc_val};
    // format select; width mode is not used here
    assign fmt_out = result_format_sel ? fmt_tc : fmt_sm;

    // sequencer next state
    always_comb begin
        state_next  = state_reg;
        status_next = status_reg;
        case (state_reg)
            ACC_IDLE: begin
                if (start_req) begin
                    status_next = 1'b1;
                    state_next  = rc_clock ? ACC_DELAY : ACC_CONVERT;
                end
            end
            ACC_DELAY: begin
                if (delay_reg == `ACC_INSTR_CYCLES - 2'd1) begin
                    state_next = ACC_CONVERT;
                end
            end
            ACC_CONVERT: begin
                if (complete) begin
                    state_next  = ACC_IDLE;
                    status_next = 1'b0;
                end
            end
            default: begin
                state_next  = ACC_IDLE;
                status_next = 1'b0;
            end
        endcase
        if (state_reg != ACC_IDLE && (sw_clear || sleep_abort)) begin
            state_next  = ACC_IDLE;
            status_next = 1'b0;
        end
        if (!enable_reg) begin
            state_next  = ACC_IDLE;
            status_next = 1'b0;
        end
    end

    // sequencer and status registers; reset clears all
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg  <= ACC_IDLE;
            status_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            status_reg <= status_next;
        end
    end

    // enable bit, written by software only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enable_reg <= 1'b0;
        end else if (ctrl0_wr) begin
            enable_reg <= ctrl0_wdata[`ACC_CTRL0_ENABLE_BIT];
        end
    end

    // bit period and start delay counters
    always_ff @(posedge clk_sys) begin
        if (sys_rst || state_reg == ACC_IDLE) begin
            period_reg <= 4'd0;
            delay_reg  <= 2'd0;
        end else begin
            if (state_reg == ACC_DELAY) begin
                delay_reg <= delay_reg + 2'd1;
            end
            if (state_reg == ACC_CONVERT && tick) begin
                period_reg <= period_reg + 4'd1;
            end
        end
    end

    // flag set on every completion; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            flag_reg <= 1'b0;
        end else if (complete) begin
            flag_reg <= 1'b1;
        end else if (done_flag_clear) begin
            flag_reg <= 1'b0;
        end
    end

    // start clears results; completion loads formatted value
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            result_reg <= `ACC_RESULT_RESET;
        end else if (start_req) begin
            result_reg <= `ACC_RESULT_RESET;
        end else if (complete) begin
            result_reg <= fmt_out;
        end
    end

    // irq, wake and vector; core power
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_reg       <= 1'b0;
            wake_reg      <= 1'b0;
            isr_reg       <= 1'b0;
            power_reg     <= 1'b0;
            trst_reg      <= 1'b0;
            trig_prev_reg <= 1'b0;
        end else begin
            irq_reg       <= conv_irq_enable && (flag_reg || complete);
            // wake only while asleep; cpu then runs the next instruction first
            wake_reg      <= cpu_sleep && conv_irq_enable && (flag_reg || complete);
            isr_reg       <= conv_irq_enable && (flag_reg || complete) &&
                             global_irq_enable && periph_irq_enable;
            // asleep, the core stays up only for a running rc conversion
            power_reg     <= enable_reg &&
                             (!cpu_sleep || (rc_clock && state_next != ACC_IDLE));
            // timer reset on accepted trigger edge
            trst_reg      <= trig_edge && start_req;
            trig_prev_reg <= trig_level;
        end
    end

    assign converter_enable = enable_reg;
    assign conv_status      = status_reg;
    assign conv_done_flag   = flag_reg;
    assign conv_irq         = irq_reg;
    assign cpu_wake         = wake_reg;
    assign cpu_vector_isr   = isr_reg;
    assign core_powered     = power_reg;
    assign timer_reset      = trst_reg;
    assign result_high      = result_reg[15:8];
    assign result_low       = result_reg[7:0];
endmodule
`default_nettype wire

// ===== verif/acc_conv_checker.sv
// acc_conv_checker.sv: port-level timing checks for the converter control.
// assumes a bind onto acc_conv_ctrl; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module acc_conv_checker (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // watched controls
    input wire logic [2:0] conv_clock_select,
    input wire logic       result_format_sel,
    input wire logic       conv_irq_enable,
    input wire logic       global_irq_enable,
    input wire logic       periph_irq_enable,
    input wire logic       cpu_sleep,
    // watched status and results
    input wire logic       converter_enable,
    input wire logic       conv_status,
    input wire logic       conv_done_flag,
    input wire logic       conv_irq,
    input wire logic       cpu_wake,
    input wire logic       cpu_vector_isr,
    input wire logic       core_powered,
    input wire logic       timer_reset,
    input wire logic [7:0] result_high,
    input wire logic [7:0] result_low
);
    // one domain; reset silences every check
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_done_ends_busy: assert property ($rose(conv_done_flag) |-> $fell(conv_status))
        else $error("done flag rose while status stayed set");
    a_irq_gated: assert property (conv_irq |-> $past(conv_irq_enable) && (conv_done_flag || $past(conv_done_flag)))
        else $error("irq without enable and flag");
    a_wake_cause: assert property (cpu_wake |-> $past(cpu_sleep) && conv_irq)
        else $error("wake without sleeping irq");
    a_isr_gate: assert property (cpu_vector_isr |-> $past(global_irq_enable && periph_irq_enable))
        else $error("isr vector without global enables");
    a_off_idle: assert property (!converter_enable |-> !conv_status)
        else $error("busy while disabled");
    a_start_clears: assert property ($rose(conv_status) |-> {result_high, result_low} == 16'h0000)
        else $error("results not cleared at start");
    a_sm_layout: assert property ($rose(conv_done_flag) && !result_format_sel |-> result_low[3:1] == 3'h0)
        else $error("sign-magnitude low bits not zero");
    a_twos_ext: assert property ($rose(conv_done_flag) && result_format_sel |-> result_high[7:5] == {3{result_high[4]}})
        else $error("twos result not sign extended");
    a_trig_pulse: assert property (timer_reset |-> conv_status ##1 !timer_reset)
        else $error("timer reset not a single pulse with status");
    a_conv_len: assert property ($rose(conv_status) && conv_clock_select == 3'b000 |-> conv_status [*8] ##22 conv_status ##1 !conv_status)
        else $error("divide-by-2 conversion length wrong");
    a_sleep_abort: assert property (cpu_sleep && conv_status && conv_clock_select[1:0] != 2'b11 |-> ##[1:2] !conv_status && !core_powered)
        else $error("sleep did not abort a system-clock conversion");
endmodule
`default_nettype wire

// ===== verif/acc_far_model.sv
// acc_far_model.sv: analog core sample source and trigger peripherals.
// assumes the bench commands samples and trigger events by task call.
`timescale 1ns/1ps
`default_nettype none
module acc_far_model (
    // clock
    input  wire logic        clk_sys,
    // sample and trigger lines
    output var  logic [12:0] core_sample,
    output var  logic        capcomp_unit_1,
    output var  logic        capcomp_unit_2,
    output var  logic [5:0]  pwm_ctrl_events
);
    // lines 0,1 capture units, 2..7 pwm events
    logic [7:0] src_reg = 8'h00;
    initial core_sample = 13'h0000;
    assign {pwm_ctrl_events, capcomp_unit_2, capcomp_unit_1} = src_reg;
    // sample driven at the next clock edge and held until the next call
    task automatic set_sample(input logic [12:0] s);
        @(posedge clk_sys);
        core_sample <= s;
    endtask
    // each event is followed by idle time before the next
    task automatic fire(input int idx);
        @(posedge clk_sys);
        src_reg[idx] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        src_reg <= 8'h00;
        repeat (2) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// testbench.sv: self-checking bench for the converter control block.
// assumes acc_conv_ctrl, acc_far_model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // stimulus into the block
    logic        clk_sys = 1'b0, sys_rst = 1'b1, ctrl0_wr = 1'b0, result_format_sel = 1'b0;
    logic        result_width_mode = 1'b0, conv_irq_enable = 1'b0, global_irq_enable = 1'b0;
    logic        periph_irq_enable = 1'b0, done_flag_clear = 1'b0, cpu_sleep = 1'b0;
    logic [7:0]  ctrl0_wdata = 8'h00;
    logic [2:0]  conv_clock_select = 3'b000;
    logic [3:0]  auto_trigger_select = 4'h0;
    // far side lines and block outputs
    logic        capcomp_unit_1, capcomp_unit_2, converter_enable, conv_status, conv_done_flag;
    logic        conv_irq, cpu_wake, cpu_vector_isr, core_powered, timer_reset;
    logic [5:0]  pwm_ctrl_events;
    logic [12:0] core_sample;
    logic [7:0]  result_high, result_low;
    int          miscompares = 0, checked = 0, n, pulses = 0;
    wire  [7:0]  outs = {converter_enable, conv_status, conv_done_flag, conv_irq, cpu_wake,
                         cpu_vector_isr, core_powered, timer_reset};
    always #10 clk_sys = ~clk_sys;
    // count timer reset pulses to prove one per trigger
    always @(posedge clk_sys) if (timer_reset === 1'b1) pulses++;
    acc_conv_ctrl uut (.clk_sys, .sys_rst, .ctrl0_wr, .ctrl0_wdata, .result_format_sel,
        .result_width_mode, .conv_clock_select, .auto_trigger_select, .conv_irq_enable,
        .global_irq_enable, .periph_irq_enable, .done_flag_clear, .cpu_sleep, .capcomp_unit_1,
        .capcomp_unit_2, .pwm_ctrl_events, .core_sample, .converter_enable, .conv_status,
        .conv_done_flag, .conv_irq, .cpu_wake, .cpu_vector_isr, .core_powered, .timer_reset,
        .result_high, .result_low);
    acc_far_model far (.clk_sys, .core_sample, .capcomp_unit_1, .capcomp_unit_2, .pwm_ctrl_events);
    task automatic complete_run;
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // one-cycle write strobe; returns just after the taking edge
    task automatic wr(input logic [7:0] d);
        @(posedge clk_sys);
        ctrl0_wr <= 1'b1;
        ctrl0_wdata <= d;
        @(posedge clk_sys);
        ctrl0_wr <= 1'b0;
        #1;
    endtask
    // count cycles the status bit stays set
    task automatic busy;
        n = 0;
        while (conv_status === 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
    endtask
    // enable written earlier, start with the enable bit kept set, then poll
    task automatic go;
        wr(8'h03);
        chk({result_high, result_low}, 16'h0000);
        busy;
        chk(16'(conv_done_flag), 16'h1);
    endtask
    task automatic clr;
        @(posedge clk_sys);
        done_flag_clear <= 1'b1;
        @(posedge clk_sys);
        done_flag_clear <= 1'b0;
        #1;
        chk(16'(conv_done_flag), 16'h0);
    endtask
    // start requests while disabled are ignored
    task automatic t_disabled;
        wr(8'h02);
        chk(16'(conv_status), 16'h0);
        cyc(1);
        auto_trigger_select <= 4'h1;
        far.fire(0);
        #1;
        chk(16'(conv_status), 16'h0);
        wr(8'h01);
    endtask
    // every clock code except 111 and its conversion length
    task automatic t_clocks;
        logic [2:0] code [7] = '{3'b000, 3'b100, 3'b001, 3'b101, 3'b010, 3'b110, 3'b011};
        int div [7] = '{2, 4, 8, 16, 32, 64, 80};
        for (int i = 0; i < 7; i++) begin
            cyc(1);
            conv_clock_select <= code[i];
            go;
            chk(16'(n), 16'(15 * div[i] + (i == 6 ? 3 : 0)));
            chk(16'(conv_irq), 16'h0);
            clr;
        end
    endtask
    // both encodings over signed samples
    task automatic t_format;
        logic [12:0] smp [4] = '{13'h0933, 13'h1001, 13'h1fff, 13'h1000};
        logic [15:0] sm [4] = '{16'h9330, 16'h0011, 16'hfff1, 16'h0001};
        logic [15:0] tc [4] = '{16'h0933, 16'hffff, 16'hf001, 16'hf000};
        for (int i = 0; i < 8; i++) begin
            far.set_sample(smp[i/2]);
            result_format_sel <= i[0];
            go;
            chk({result_high, result_low}, i[0] ? tc[i/2] : sm[i/2]);
            clr;
        end
    endtask
    // irq gating and vectoring
    task automatic t_irq;
        conv_irq_enable <= 1'b1;
        go;
        cyc(2);
        #1;
        chk({conv_irq, cpu_vector_isr}, 16'h2);
        global_irq_enable <= 1'b1;
        periph_irq_enable <= 1'b1;
        cyc(2);
        #1;
        chk(16'(cpu_vector_isr), 16'h1);
        clr;
        cyc(2);
        #1;
        chk({conv_irq, cpu_vector_isr}, 16'h0);
        {global_irq_enable, periph_irq_enable} <= 2'b00;
    endtask
    // abort mid-conversion, and reset mid-conversion
    task automatic t_abort;
        conv_clock_select <= 3'b110;
        wr(8'h03);
        cyc(10);
        wr(8'h01);
        chk(16'({conv_status, conv_done_flag}), 16'h0);
        chk({result_high, result_low}, 16'h0);
        cyc(980);
        #1;
        chk(16'(conv_done_flag), 16'h0);
        wr(8'h03);
        cyc(5);
        sys_rst <= 1'b1;
        cyc(1);
        sys_rst <= 1'b0;
        #1;
        chk({outs, result_high}, 16'h0);
        wr(8'h01);
    endtask
    // sleep with rc clock (irq on, irq off) and with a divider clock
    task automatic t_sleep;
        for (int i = 0; i < 2; i++) begin
            conv_clock_select <= 3'b111;
            conv_irq_enable <= !i[0];
            wr(8'h03);
            cpu_sleep <= 1'b1;
            busy;
            chk(16'(conv_done_flag), 16'h1);
            cyc(3);
            #1;
            chk({converter_enable, cpu_wake, core_powered}, i[0] ? 16'h4 : 16'h6);
            cpu_sleep <= 1'b0;
            clr;
        end
        conv_clock_select <= 3'b001;
        wr(8'h03);
        cyc(5);
        cpu_sleep <= 1'b1;
        cyc(3);
        #1;
        chk({converter_enable, conv_status, core_powered, conv_done_flag}, 16'h8);
        cpu_sleep <= 1'b0;
    endtask
    // every trigger source, then a reserved code
    task automatic t_trigger;
        logic [3:0] ts [8] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
        conv_clock_select <= 3'b110;
        for (int i = 0; i < 9; i++) begin
            cyc(1);
            auto_trigger_select <= (i < 8) ? ts[i] : 4'h3;
            n = pulses;
            far.fire(i < 8 ? i : 0);
            #1;
            chk({conv_status, 15'(pulses - n)}, i < 8 ? 16'h8001 : 16'h0);
            wr(8'h01);
        end
    endtask
    initial begin
        cyc(16);
        sys_rst <= 1'b0;
        cyc(1);
        #1;
        chk({outs, result_low}, 16'h0);
        t_disabled;
        t_clocks;
        t_format;
        t_irq;
        t_abort;
        t_sleep;
        t_trigger;
        complete_run;
    end
    // watchdog against a hung handshake
    initial begin
        cyc(40000);
        miscompares++;
        complete_run;
    end
endmodule
bind acc_conv_ctrl acc_conv_checker chk_i (.clk_sys, .sys_rst, .conv_clock_select,
    .result_format_sel, .conv_irq_enable, .global_irq_enable, .periph_irq_enable, .cpu_sleep,
    .converter_enable, .conv_status, .conv_done_flag, .conv_irq, .cpu_wake, .cpu_vector_isr,
    .core_powered, .timer_reset, .result_high, .result_low);
`default_nettype wire
